// *** design/soft_strap_pkg.sv ***
// constants, types and decode helpers of the soft strap loader
// Functional notes
// R1 - software writes strap values after reset, then sets the done bit last
// R2 - setting done bit 15 makes an internal reset pulse and captures straps
// R3 - done bit is read/write, resets to 0; at 1 the reset sequence finishes
// R4 - bit 14 enables automatic crossover when 1, disables it when 0
// R5 - captured crossover value is copied to bit 15 of the PHY control register
// R6 - bits 13 and 12:11 form a code: forced modes or advertised abilities
// R7 - decoded code is latched into basic mode control and advertisement bits
// R8 - bit 10 set picks indicator mode 1, else mode 2 or 3 by control bits 6:5
// R9 - captured indicator value decides the indicator scheme in effect
// R10 - bits 14:10 default to the strap pin levels sampled at reset
package soft_strap_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] IDX_BASIC_MODE  = 6'h00;
    localparam logic [5:0] IDX_ADVERT      = 6'h04;
    localparam logic [5:0] IDX_SOFT_STRAP  = 6'h09;
    localparam logic [5:0] IDX_INDICATOR   = 6'h18;
    localparam logic [5:0] IDX_PHY_CONTROL = 6'h1C;
    localparam logic [5:0] IDX_LOADER      = 6'h1D;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DONE_BIT       = 15;
    localparam int STRAP_LO       = 10;
    localparam int BMC_SPEED_BIT  = 13;
    localparam int BMC_NEG_BIT    = 12;
    localparam int BMC_DUPLEX_BIT = 8;
    localparam int ADV_LO         = 5;
    localparam int XOVER_BIT      = 15;
    localparam int LED_SEL_LO     = 5;
    localparam int LDR_BUSY_BIT   = 8;
    localparam int LDR_DONE_BIT   = 9;

    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [4:0] ADV_SELECTOR    = 5'h01;
    localparam logic       OVERRIDE_RESET  = 1'h1;
    localparam logic [1:0] LED_SEL_RESET   = 2'h0;
    localparam int         CLK_PERIOD_NS   = 50;
    localparam int         PULSE_TIME_NS   = 200;
    localparam int         PULSE_CYCLES    =
        (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] PULSE_LAST      = 3'(PULSE_CYCLES - 1);
    localparam logic [1:0] IND_MODE_1      = 2'h1;
    localparam logic [1:0] IND_MODE_2      = 2'h2;
    localparam logic [1:0] IND_MODE_3      = 2'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic       crossover;
        logic       negotiation_enable_strap;
        logic [1:0] link_mode_select;
        logic       indicator_scheme_select;
    } strap_t;

    // advertise order: 100 full, 100 half, 10 full, 10 half
    typedef struct packed {
        logic       negotiation_enable;
        logic       speed_100;
        logic       full_duplex;
        logic [3:0] advertise;
    } link_cfg_t;

    typedef enum logic [1:0] {
        st_unfinished,
        st_reset_pulse,
        st_complete
    } loader_state_t;

    function automatic link_cfg_t decode_link(input strap_t s);
        link_cfg_t c;
        c.negotiation_enable = s.negotiation_enable_strap;
        if (s.negotiation_enable_strap) begin
            unique case (s.link_mode_select)
                2'h0:    c.advertise = 4'h3;
                2'h1:    c.advertise = 4'hC;
                2'h2:    c.advertise = 4'h5;
                default: c.advertise = 4'hF;
            endcase
            c.speed_100   = c.advertise[3] | c.advertise[2];
            c.full_duplex = c.advertise[3] | c.advertise[1];
        end else begin
            c.speed_100   = s.link_mode_select[1];
            c.full_duplex = s.link_mode_select[0];
            c.advertise   = 4'h1 << {s.link_mode_select[1], s.link_mode_select[0]};
        end
        return c;
    endfunction

endpackage

// *** design/soft_strap_config_loader.sv ***
// soft strap loader with apb register slave
`timescale 1ns/1ps

module soft_strap_config_loader
    import soft_strap_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire strap_t      strap_pins,
    output logic             crossover_enable,
    output link_cfg_t        link_config,
    output logic      [1:0]  indicator_mode,
    output logic             internal_reset_pulse,
    output logic             reset_sequence_done
);

    // ************************************************************
    // state
    // ************************************************************
    loader_state_t state;
    loader_state_t next_state;
    logic          strap_sampled;
    strap_t        pin_value;
    strap_t        soft_value;
    strap_t        latched;
    logic          done_bit;
    logic          override_enable;
    logic [1:0]    led_select;
    logic [2:0]    pulse_count;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire [5:0] idx         = paddr[7:2];
    wire       in_range    = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
    wire       hit_basic   = idx == IDX_BASIC_MODE;
    wire       hit_advert  = idx == IDX_ADVERT;
    wire       hit_soft    = idx == IDX_SOFT_STRAP;
    wire       hit_ind     = idx == IDX_INDICATOR;
    wire       hit_phy     = idx == IDX_PHY_CONTROL;
    wire       hit_loader  = idx == IDX_LOADER;
    wire       hit_any     = hit_basic | hit_advert | hit_soft
                           | hit_ind | hit_phy | hit_loader;
    wire       mapped      = in_range & hit_any;
    wire       setup_phase = psel & ~penable;
    wire       access_done = psel & penable & pready;
    wire       wr_ok       = access_done & pwrite & mapped;
    wire       wr_soft     = wr_ok & hit_soft & pstrb[1];
    wire       wr_ind      = wr_ok & hit_ind & pstrb[0];
    wire       wr_loader   = wr_ok & hit_loader & pstrb[0];

    // ************************************************************
    // soft strap register fields
    // ************************************************************
    // software owns bits 15:10 once strap defaults are in
    wire       next_done    = wr_soft ? pwdata[DONE_BIT] : done_bit;   // [R3]
    wire       done_rise    = wr_soft & pwdata[DONE_BIT] & ~done_bit;   // [R2]
    wire       done_clear   = wr_soft & ~pwdata[DONE_BIT];
    wire [4:0] written_bits = pwdata[DONE_BIT-1:STRAP_LO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_sampled <= 1'b0;
            pin_value     <= '0;
            soft_value    <= '0;
        end else if (!strap_sampled) begin
            strap_sampled <= 1'b1;
            pin_value     <= strap_pins;                               // [R10]
            soft_value    <= strap_pins;                               // [R10]
        end else if (wr_soft) begin
            soft_value    <= strap_t'(written_bits);                   // [R4] [R6] [R8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_bit <= 1'b0;
        end else begin
            done_bit <= next_done;                                     // [R3]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            override_enable <= OVERRIDE_RESET;
            led_select      <= LED_SEL_RESET;
        end else begin
            if (wr_loader) begin
                override_enable <= pwdata[0];
            end
            if (wr_ind) begin
                led_select <= pwdata[LED_SEL_LO+1:LED_SEL_LO];
            end
        end
    end

    // ************************************************************
    // loader sequence
    // ************************************************************
    wire pulse_end = (state == st_reset_pulse) && (pulse_count == PULSE_LAST);

    always_comb begin
        next_state = state;
        unique case (state)
            st_unfinished: begin
                if (done_rise) begin
                    next_state = st_reset_pulse;                       // [R2]
                end
            end
            st_reset_pulse: begin
                if (pulse_end) begin
                    next_state = st_complete;                          // [R3]
                end
            end
            st_complete: begin
                if (done_clear) begin
                    next_state = st_unfinished;                        // [R3]
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_unfinished;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_count <= 3'h0;
        end else if (state == st_reset_pulse) begin
            pulse_count <= pulse_count + 3'h1;
        end else begin
            pulse_count <= 3'h0;
        end
    end

    // capture at end of pulse so a write that also sets done is seen
    wire    capture_now = pulse_end;
    wire    use_soft    = override_enable;
    strap_t capture_src;
    assign  capture_src = use_soft ? soft_value : pin_value;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched <= '0;
        end else if (!strap_sampled) begin
            latched <= strap_pins;                                     // [R10]
        end else if (capture_now) begin
            latched <= capture_src;                                    // [R2]
        end
    end

    // ************************************************************
    // captured configuration outputs
    // ************************************************************
    link_cfg_t  decoded;
    logic [1:0] scheme;
    assign decoded = decode_link(latched);                              // [R6]
    assign scheme  = latched.indicator_scheme_select ? IND_MODE_1 :
                     (led_select == 2'h0)            ? IND_MODE_2 :
                                                       IND_MODE_3;    // [R8]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crossover_enable     <= 1'b0;
            link_config          <= '0;
            indicator_mode       <= IND_MODE_2;
            internal_reset_pulse <= 1'b0;
            reset_sequence_done  <= 1'b0;
        end else begin
            crossover_enable     <= latched.crossover;                 // [R4] [R5]
            link_config          <= decoded;                           // [R7]
            indicator_mode       <= scheme;                            // [R9]
            internal_reset_pulse <= next_state == st_reset_pulse;      // [R2]
            reset_sequence_done  <= next_state == st_complete;         // [R3]
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    wire [15:0] rd_basic  = (16'(link_config.speed_100)          << BMC_SPEED_BIT)
                          | (16'(link_config.negotiation_enable) << BMC_NEG_BIT)
                          | (16'(link_config.full_duplex)        << BMC_DUPLEX_BIT);
    wire [15:0] rd_advert = (16'(link_config.advertise) << ADV_LO)
                          | 16'(ADV_SELECTOR);
    wire [15:0] rd_soft   = {done_bit, soft_value, 10'h000};
    wire [15:0] rd_ind    = 16'(led_select) << LED_SEL_LO;
    wire [15:0] rd_phy    = 16'(crossover_enable) << XOVER_BIT;        // [R5]
    wire [15:0] rd_loader = (16'(reset_sequence_done)  << LDR_DONE_BIT)
                          | (16'(internal_reset_pulse) << LDR_BUSY_BIT)
                          | 16'(override_enable);

    wire [15:0] rd_value  = hit_basic  ? rd_basic  :
                            hit_advert ? rd_advert :
                            hit_soft   ? rd_soft   :
                            hit_ind    ? rd_ind    :
                            hit_phy    ? rd_phy    :
                            hit_loader ? rd_loader :
                                         16'h0000;
    wire        rd_ok     = setup_phase & ~pwrite & mapped;

    // ************************************************************
    // apb answer: one access cycle, no extra wait
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata  <= rd_ok ? {16'h0000, rd_value} : 32'h0000_0000;
        end
    end

endmodule

// *** test/soft_strap_config_loader_asserts.sv ***
// assertion checker of the soft strap loader
`timescale 1ns/1ps
module soft_strap_config_loader_asserts
    import soft_strap_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        crossover_enable,
    input wire link_cfg_t   link_config,
    input wire logic        internal_reset_pulse,
    input wire logic        reset_sequence_done
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire rd_acc = acc && !pwrite;
    wire done_wr = acc && pwrite && paddr == 12'h024 && pstrb[1] && pwdata[15];
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside access");
    property p_start;
        done_wr && !reset_sequence_done && !internal_reset_pulse
            |-> ##[1:3] $rose(internal_reset_pulse);
    endproperty
    a_start: assert property (p_start) else $error("no pulse after done");
    property p_len;
        $rose(internal_reset_pulse) |-> internal_reset_pulse[*4] ##1 !internal_reset_pulse;
    endproperty
    a_len: assert property (p_len) else $error("pulse width wrong");
    property p_seq; $fell(internal_reset_pulse) |-> reset_sequence_done; endproperty
    a_seq: assert property (p_seq) else $error("sequence not done");
    property p_excl; !(internal_reset_pulse && reset_sequence_done); endproperty
    a_excl: assert property (p_excl) else $error("pulse during done");
    property p_xreg;
        rd_acc && paddr == 12'h070 |-> prdata[15] == crossover_enable;
    endproperty
    a_xreg: assert property (p_xreg) else $error("control bit mismatch");
    property p_bmc;
        rd_acc && paddr == 12'h000 |-> prdata[12] == link_config.negotiation_enable
            && prdata[13] == link_config.speed_100 && prdata[8] == link_config.full_duplex;
    endproperty
    a_bmc: assert property (p_bmc) else $error("mode register mismatch");
    property p_hold;
        reset_sequence_done && $past(reset_sequence_done, 2)
            |-> $stable(crossover_enable) && $stable(link_config);
    endproperty
    a_hold: assert property (p_hold) else $error("latched value moved");
    c_done: cover property ($rose(reset_sequence_done));
    c_err: cover property (pslverr);
    c_wr: cover property (done_wr);
endmodule

bind soft_strap_config_loader soft_strap_config_loader_asserts u_asserts (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .crossover_enable, .link_config, .internal_reset_pulse, .reset_sequence_done);

// *** test/soft_strap_config_loader_tb_top.sv ***
// self-checking bench of the soft strap loader
`timescale 1ns/1ps
module soft_strap_config_loader_tb_top
    import soft_strap_pkg::*;
;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, crossover_enable, internal_reset_pulse, err, seq_done;
    strap_t      strap_pins = 5'h0, s;
    link_cfg_t   link_config;
    logic [1:0]  indicator_mode, led;
    logic [6:0]  e;
    int          fail_count = 0, checks = 0;

    soft_strap_config_loader u_soft_strap_config_loader (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .strap_pins,
        .crossover_enable, .link_config, .indicator_mode, .internal_reset_pulse,
        .reset_sequence_done(seq_done));

    initial begin
        forever #25 pclk = ~pclk;
    end

    // ****
    // expectations and bus tasks
    // ****
    function automatic logic [6:0] exp_link(input strap_t t);
        logic [3:0] a;
        if (t.negotiation_enable_strap) begin
            a = (t.link_mode_select == 2'h0) ? 4'h3 : (t.link_mode_select == 2'h1) ? 4'hC :
                (t.link_mode_select == 2'h2) ? 4'h5 : 4'hF;
            return {1'h1, a[3] | a[2], a[3] | a[1], a};
        end
        return {1'h0, t.link_mode_select, 4'h1 << t.link_mode_select};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n == 20) begin
            fail_count++;
            end_of_test();
        end
    endtask

    task automatic wait_done;
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge pclk);
            if (seq_done === 1'h1) break;
        end
        if (n == 40) begin
            fail_count++;
            end_of_test();
        end
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        void'($urandom(99));
        strap_pins <= strap_t'(5'($urandom));
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h024, 32'h0);
        chk(rd, {16'h0, 1'h0, strap_pins, 10'h0});
        chk({31'h0, crossover_enable}, {31'h0, strap_pins.crossover});
        apb(1'h0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        for (int i = 0; i < 32; i++) begin
            s   = strap_t'(5'(i));
            led = 2'($urandom);
            e   = exp_link(s);
            apb(1'h1, 12'h060, {25'h0, led, 5'h0});
            chk({31'h0, seq_done}, 32'h0);
            apb(1'h1, 12'h024, {16'h0, 1'h0, s, 10'h0});
            apb(1'h1, 12'h024, {16'h0, 1'h1, s, 10'h0});
            wait_done();
            repeat (2) @(posedge pclk);
            chk({31'h0, crossover_enable}, {31'h0, s.crossover});
            chk({25'h0, link_config}, {25'h0, e});
            chk({30'h0, indicator_mode}, s.indicator_scheme_select ? 32'h1 :
                (led == 2'h0) ? 32'h2 : 32'h3);
            apb(1'h0, 12'h000, 32'h0);
            chk(rd, {18'h0, e[5], e[6], 3'h0, e[4], 8'h0});
            apb(1'h0, 12'h010, 32'h0);
            chk(rd, {23'h0, e[3:0], 5'h01});
            apb(1'h0, 12'h024, 32'h0);
            chk(rd, {16'h0, 1'h1, s, 10'h0});
            apb(1'h1, 12'h024, {16'h0, 1'h0, s, 10'h0});
        end
        // override off: capture takes the pin levels, not the soft values
        s = ~strap_pins;
        apb(1'h1, 12'h074, 32'h0);
        apb(1'h0, 12'h074, 32'h0);
        chk(rd, 32'h0);
        apb(1'h1, 12'h024, {16'h0, 1'h1, s, 10'h0});
        apb(1'h0, 12'h074, 32'h0);
        chk(rd, 32'h100);
        wait_done();
        repeat (2) @(posedge pclk);
        chk({31'h0, crossover_enable}, {31'h0, strap_pins.crossover});
        chk({25'h0, link_config}, {25'h0, exp_link(strap_pins)});
        apb(1'h0, 12'h070, 32'h0);
        chk(rd, {16'h0, strap_pins.crossover, 15'h0});
        chk({31'h0, err}, 32'h0);
        apb(1'h0, 12'h074, 32'h0);
        chk(rd, 32'h200);
        // done written again while set: no new pulse
        apb(1'h1, 12'h024, {16'h0, 1'h1, s, 10'h0});
        @(posedge pclk);
        chk({31'h0, internal_reset_pulse}, 32'h0);
        // write without the upper lane strobe is ignored
        pstrb <= 4'h1;
        apb(1'h1, 12'h024, 32'h0);
        pstrb <= 4'hF;
        apb(1'h0, 12'h024, 32'h0);
        chk(rd, {16'h0, 1'h1, s, 10'h0});
        end_of_test();
    end
endmodule
